// ==== core/halt_wakeup_reset_control.sv ====
// power-down, wake-up and reset sequencer with a wishbone register slave
// Functional notes
// R01: sleep stops system oscillator; watchdog oscillator runs when selected.
// R02: core memory and registers are frozen during power-down.
// R03: entering power-down clears watchdog when it uses its own oscillator.
// R04: port pins keep their drive and sense state during power-down.
// R05: sleep sets power-down flag and clears timeout flag.
// R06: wake on reset pin, interrupt, port A falling edge, watchdog overflow.
// R07: power-down flag cleared by power-up and clear-watchdog, set by sleep.
// R08: timeout sets its flag; in power-down it wakes with warm reset.
// R09: each port A bit has own wake enable; wake resumes next instruction.
// R10: interrupt wake is serviced if enabled and stack not full.
// R11: interrupt already pending at sleep is not a wake source.
// R12: every wake-up inserts a 1024-cycle dummy period.
// R13: next instruction right after dummy; interrupt entry one cycle later.
// R14: flags: power-up 0,0; pin run u,u; pin halt 0,1; wdt 1,u/1,1.
// R15: 1024-cycle start-up delay for all resets and every wake.
// R16: full resets also add an option load delay.
// R17: full reset clears pc, disables ints, clears wdt, ports to input.
// R18: full reset loads the fixed initial register values.
// R19: warm reset clears only program counter low byte.
// R20: reset pin gives full initialisation in run and in power-down.
// R21: overflow in run is full reset with timeout; in halt warm reset.
// R22: pin wake events are caught and synchronised to the clock.
`timescale 1ns/1ps
`include "halt_wake_params.svh"

module halt_wakeup_reset_control (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // core and watchdog events
  input  wire logic        sleep_i,
  input  wire logic        clear_watchdog_instruction_i,
  input  wire logic        wdt_ovf_i,
  input  wire logic [2:0]  int_req_i,
  input  wire logic [2:0]  int_en_i,
  input  wire logic        emi_i,
  input  wire logic        stack_full_i,
  // pins
  input  wire logic        reset_pin_n_i,
  input  wire logic [7:0]  port_a_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // control to the rest of the chip
  output logic             osc_run_o,
  output logic             wdt_osc_run_o,
  output logic             wdt_clear_o,
  output logic             hold_o,
  output logic             core_reset_o,
  output logic             opt_load_o,
  output logic             warm_reset_o,
  output logic             pc_low_clear_o,
  output logic             resume_o,
  output logic             int_ack_o,
  output logic             timeout_flag_o,
  output logic             power_down_flag_o,
  output logic [7:0]       interrupt_control_reg_init_o,
  output logic [7:0]       timer_control_reg_init_o,
  output logic [7:0]       port_init_o,
  output logic [7:0]       amp_init_o,
  output logic [7:0]       conv_ctrl_init_o,
  output logic [2:0]       conv_clk_init_o
);

  import halt_wake_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic       res_m_r, res_s_r;
  logic [7:0] pa_m_r, pa_s_r, pa_d_r;

  // clock assumed to reach this block while the core oscillator is off
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      res_m_r <= 1'b1;
      res_s_r <= 1'b1;
      pa_m_r  <= 8'hFF;
      pa_s_r  <= 8'hFF;
      pa_d_r  <= 8'hFF;
    end else begin
      res_m_r <= reset_pin_n_i;  // [R22]
      res_s_r <= res_m_r;
      pa_m_r  <= port_a_i;       // [R22]
      pa_s_r  <= pa_m_r;
      pa_d_r  <= pa_s_r;
    end
  end

  // ****************************************************************
  // registers reached over wishbone
  // ****************************************************************
  logic [1:0] ctrl_r;
  logic [7:0] wake_en_r;
  logic       ack_r;
  logic [31:0] rd_dat_r;
  state_t     state_r, state_nxt;
  wake_kind_t kind_r, kind_nxt;
  logic       to_r, to_nxt, pdf_r, pdf_nxt;

  wire        wb_req   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
  wire        sel_ctrl = (wb_adr_i == `CTRL_OFS);
  wire        sel_wken = (wb_adr_i == `WAKE_EN_OFS);
  wire        sel_stat = (wb_adr_i == `STATUS_OFS);
  wire        wdt_sel  = ctrl_r[`CTRL_WDT_SEL];
  wire        wdt_en   = ctrl_r[`CTRL_WDT_EN];
  wire [31:0] status_w = {22'h0, kind_r, state_r, to_r, pdf_r};
  wire [31:0] rd_mux   = sel_ctrl ? {30'h0, ctrl_r} :
                         sel_wken ? {24'h0, wake_en_r} :
                         sel_stat ? status_w : 32'h0;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ctrl_r    <= `CTRL_RST;
      wake_en_r <= `WAKE_EN_RST;
      ack_r     <= 1'b0;
      rd_dat_r  <= 32'h0;
    end else begin
      ack_r    <= wb_req;
      rd_dat_r <= wb_req ? rd_mux : 32'h0;
      if (wb_wr && sel_ctrl)
        ctrl_r <= wb_dat_i[1:0];
      if (wb_wr && sel_wken)
        wake_en_r <= wb_dat_i[7:0];  // [R09]
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_dat_r;

  // ****************************************************************
  // event decode
  // ****************************************************************
  logic [2:0] pend_mask_r;
  logic       cnt_zero;

  wire        in_run    = (state_r == S_RUN);
  wire        in_halt   = (state_r == S_HALT);
  wire        in_wake   = (state_r == S_WAKE);
  wire        res_act   = ~res_s_r;
  wire        ovf_run   = in_run & wdt_ovf_i & ~res_act;
  wire        sleep_go  = in_run & sleep_i & ~res_act & ~wdt_ovf_i;
  wire        ovf_halt  = in_halt & wdt_ovf_i & ~res_act;
  wire [2:0]  int_new   = int_req_i & ~pend_mask_r;           // [R11]
  wire        int_wake  = |int_new;
  wire        int_serve = |(int_new & int_en_i) & emi_i & ~stack_full_i;  // [R10]
  wire        pa_wake   = |(pa_d_r & ~pa_s_r & wake_en_r);     // [R09]
  wire        any_wake  = in_halt & ~res_act & (wdt_ovf_i | int_wake | pa_wake);  // [R06]

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    case (state_r)
      S_LOAD: begin
        if (!res_act && cnt_zero)
          state_nxt = S_SST;                                 // [R16]
      end
      S_SST: begin
        if (res_act)
          state_nxt = S_LOAD;
        else if (cnt_zero)
          state_nxt = S_RUN;                                 // [R15]
      end
      S_RUN: begin
        if (res_act || wdt_ovf_i)
          state_nxt = S_LOAD;                                // [R20] [R21]
        else if (sleep_i)
          state_nxt = S_HALT;                                // [R01]
      end
      S_HALT: begin
        if (res_act)
          state_nxt = S_LOAD;                                // [R20]
        else if (any_wake) begin
          state_nxt = S_WAKE;                                // [R12]
          if (wdt_ovf_i)
            kind_nxt = WK_WARM;                              // [R08]
          else if (int_wake && int_serve)
            kind_nxt = WK_ACK;
          else
            kind_nxt = WK_RESUME;
        end
      end
      S_WAKE: begin
        if (res_act)
          state_nxt = S_LOAD;
        else if (cnt_zero)
          state_nxt = (kind_r == WK_ACK) ? S_ACK : S_RUN;    // [R13]
      end
      S_ACK: state_nxt = S_RUN;
      default: state_nxt = S_LOAD;
    endcase
  end

  // one counter serves the option load, start-up and dummy periods
  wire        enter_ld  = (state_nxt == S_LOAD) & ((state_r != S_LOAD) | res_act);
  wire        enter_tm  = (state_nxt != state_r) &
                          ((state_nxt == S_SST) | (state_nxt == S_WAKE));
  wire [`CNT_W-1:0] cnt_val = enter_ld ? `OPT_LOAD_CYC - `CNT_W'd1 :
                                         `SST_CYC - `CNT_W'd1;

  down_counter #(
    .RST_VAL (`OPT_LOAD_CYC - `CNT_W'd1)
  ) down_counter_i (
    .sys_clk_i  (sys_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (enter_ld | enter_tm),
    .load_val_i (cnt_val),
    .zero_o     (cnt_zero)
  );

  // ****************************************************************
  // status flags
  // ****************************************************************
  always_comb begin
    to_nxt  = to_r;
    pdf_nxt = pdf_r;
    if (in_halt && res_act)
      to_nxt = 1'b0;                                         // [R14]
    else if (ovf_run || ovf_halt)
      to_nxt = 1'b1;                                         // [R08] [R14]
    if (sleep_go) begin
      pdf_nxt = 1'b1;                                        // [R05] [R07]
      to_nxt  = 1'b0;
    end else if (in_run && clear_watchdog_instruction_i && !res_act)
      pdf_nxt = 1'b0;                                        // [R07]
  end

  // ****************************************************************
  // state and output flops
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_r     <= S_LOAD;
      kind_r      <= WK_NONE;
      to_r        <= 1'b0;                                   // [R14]
      pdf_r       <= 1'b0;
      pend_mask_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      to_r    <= to_nxt;
      pdf_r   <= pdf_nxt;
      if (sleep_go)
        pend_mask_r <= int_req_i;                            // [R11]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      osc_run_o      <= 1'b1;
      wdt_osc_run_o  <= 1'b1;
      wdt_clear_o    <= 1'b1;
      hold_o         <= 1'b0;
      core_reset_o   <= 1'b1;
      opt_load_o     <= 1'b1;
      warm_reset_o   <= 1'b0;
      pc_low_clear_o <= 1'b1;
      resume_o       <= 1'b0;
      int_ack_o      <= 1'b0;
    end else begin
      osc_run_o      <= (state_nxt != S_HALT);                         // [R01]
      wdt_osc_run_o  <= wdt_en & ((state_nxt != S_HALT) | wdt_sel);    // [R01]
      // watchdog held clear through a full reset, counts once released
      wdt_clear_o    <= (state_nxt == S_LOAD) | (state_nxt == S_SST) |
                        (sleep_go & wdt_sel);                          // [R03] [R17]
      hold_o         <= (state_nxt == S_HALT) | (state_nxt == S_WAKE); // [R02] [R04]
      core_reset_o   <= (state_nxt == S_LOAD) | (state_nxt == S_SST);  // [R17] [R18]
      opt_load_o     <= (state_nxt == S_LOAD);                         // [R16]
      warm_reset_o   <= ovf_halt;                                      // [R08] [R21]
      pc_low_clear_o <= ovf_halt | enter_ld;                           // [R19] [R17]
      resume_o       <= in_wake & cnt_zero & ~res_act & (kind_r != WK_ACK);  // [R13]
      int_ack_o      <= (state_r == S_ACK);                            // [R10] [R13]
    end
  end

  assign timeout_flag_o    = to_r;
  assign power_down_flag_o = pdf_r;

  // fixed values, handed to the core while core_reset_o is high
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      interrupt_control_reg_init_o      <= `INTERRUPT_CONTROL_REG_INIT;                        // [R18]
      timer_control_reg_init_o      <= `TIMER_CONTROL_REG_INIT;
      port_init_o      <= `PORT_INIT;
      amp_init_o       <= `AMP_INIT;
      conv_ctrl_init_o <= `CONV_CTRL_INIT;
      conv_clk_init_o  <= `CONV_CLK_INIT;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [`CNT_W-1:0] wake_cyc_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !in_wake)
      wake_cyc_r <= '0;
    else
      wake_cyc_r <= wake_cyc_r + `CNT_W'd1;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sleep_flags_a: assert property (sleep_go |=> pdf_r && !to_r && state_r == S_HALT)  // [R05]
    else $error("sleep did not set power-down state and flags");

  osc_stop_a: assert property (in_halt |-> !osc_run_o && hold_o)  // [R01]
    else $error("oscillator running or core free in power-down");

  dummy_len_a: assert property (in_wake && state_nxt == S_RUN && !res_act
                                |-> wake_cyc_r == `SST_CYC - `CNT_W'd1)  // [R12]
    else $error("dummy period not 1024 cycles");

  warm_wake_a: assert property (ovf_halt |=> to_r && pdf_r && warm_reset_o && !core_reset_o)  // [R08]
    else $error("watchdog wake did not give warm reset with flags 1,1");

  pin_halt_a: assert property (in_halt && res_act |=> !to_r && pdf_r && core_reset_o)  // [R14]
    else $error("reset pin in power-down gave wrong flags");

  ack_delay_a: assert property (in_wake && cnt_zero && !res_act && kind_r == WK_ACK
                                |=> state_r == S_ACK ##1 int_ack_o && !resume_o)  // [R13]
    else $error("interrupt entry not delayed after dummy period");

  clr_pdf_a: assert property (in_run && clear_watchdog_instruction_i && !sleep_i && !res_act |=> !pdf_r)  // [R07]
    else $error("clear-watchdog did not clear power-down flag");

  pend_int_a: assert property (in_halt && !res_act && !wdt_ovf_i && !pa_wake
                               && int_new == 3'h0 |=> in_halt)  // [R11]
    else $error("pending interrupt woke the device");

  run_ovf_a: assert property (ovf_run |=> to_r && state_r == S_LOAD && core_reset_o)  // [R21]
    else $error("watchdog overflow in run did not give full reset");

endmodule : halt_wakeup_reset_control

// ==== core/halt_wake_params.svh ====
// constants for the power-down, wake-up and reset controller
`ifndef HALT_WAKE_PARAMS_SVH
`define HALT_WAKE_PARAMS_SVH

// ****************************************************************
// timing counts, in sys_clk_i cycles
// ****************************************************************
`define SST_CYC          11'd1024
`define OPT_LOAD_CYC     11'd16
`define CNT_W            11

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CTRL_OFS         8'h00
`define WAKE_EN_OFS      8'h04
`define STATUS_OFS       8'h08

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTRL_WDT_SEL     0
`define CTRL_WDT_EN      1
`define CTRL_RST         2'h3
`define WAKE_EN_RST      8'h00
`define ST_PDF           0
`define ST_TO            1
`define ST_STATE_LSB     2
`define ST_KIND_LSB      8

// ****************************************************************
// values loaded into the core on a full reset
// ****************************************************************
`define INTERRUPT_CONTROL_REG_INIT        8'h00
`define TIMER_CONTROL_REG_INIT        8'h08
`define PORT_INIT        8'hFF
`define AMP_INIT         8'h08
`define CONV_CTRL_INIT   8'h40
`define CONV_CLK_INIT    3'h4

`endif

// ==== core/halt_wake_pkg.sv ====
// types for the power-down, wake-up and reset controller
package halt_wake_pkg;

  typedef enum logic [5:0] {
    S_LOAD = 6'h01,
    S_SST  = 6'h02,
    S_RUN  = 6'h04,
    S_HALT = 6'h08,
    S_WAKE = 6'h10,
    S_ACK  = 6'h20
  } state_t;

  typedef enum logic [1:0] {
    WK_NONE   = 2'h0,
    WK_RESUME = 2'h1,
    WK_ACK    = 2'h2,
    WK_WARM   = 2'h3
  } wake_kind_t;

endpackage : halt_wake_pkg

// ==== core/down_counter.sv ====
// loadable down counter with a zero flag
`timescale 1ns/1ps
`include "halt_wake_params.svh"

module down_counter #(
  parameter logic [`CNT_W-1:0] RST_VAL = '0
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              load_i,
  input  wire logic [`CNT_W-1:0] load_val_i,
  output logic                   zero_o
);

  logic [`CNT_W-1:0] cnt_r;

  assign zero_o = (cnt_r == '0);

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i)
      cnt_r <= RST_VAL;
    else if (load_i)
      cnt_r <= load_val_i;
    else if (!zero_o)
      cnt_r <= cnt_r - `CNT_W'd1;
  end

endmodule : down_counter

// ==== dv/core_side_model.sv ====
// core, watchdog, interrupt and pin model facing the controller
`timescale 1ns/1ps

module core_side_model (
  input  wire logic       sys_clk_i,
  input  wire logic       hold_i,
  output logic            sleep_o,
  output logic            clear_watchdog_instruction_o,
  output logic            wdt_ovf_o,
  output logic [2:0]      int_req_o,
  output logic [2:0]      int_en_o,
  output logic            emi_o,
  output logic            stack_full_o,
  output logic            reset_pin_n_o,
  output logic [7:0]      port_a_o
);
  initial begin
    sleep_o       = 1'b0;
    clear_watchdog_instruction_o     = 1'b0;
    wdt_ovf_o     = 1'b0;
    int_req_o     = 3'h0;
    int_en_o      = 3'h0;
    emi_o         = 1'b0;
    stack_full_o  = 1'b0;
    reset_pin_n_o = 1'b1;
    port_a_o      = 8'hFF;
  end

  // a frozen core executes nothing, so instructions wait for hold to drop
  task automatic instr(input logic slp, input logic clr);
    while (hold_i !== 1'b0) @(posedge sys_clk_i);
    sleep_o   <= slp;
    clear_watchdog_instruction_o <= clr;
    @(posedge sys_clk_i);
    sleep_o   <= 1'b0;
    clear_watchdog_instruction_o <= 1'b0;
  endtask : instr

  // watchdog has its own clock, so an overflow may arrive while frozen
  task automatic ovf();
    wdt_ovf_o <= 1'b1;
    @(posedge sys_clk_i);
    wdt_ovf_o <= 1'b0;
  endtask : ovf

  task automatic pins(input logic rst_n, input logic [7:0] pa);
    reset_pin_n_o <= rst_n;
    port_a_o      <= pa;
  endtask : pins

  task automatic ints(input logic [2:0] req, input logic [2:0] en, input logic emi,
                      input logic full);
    int_req_o    <= req;
    int_en_o     <= en;
    emi_o        <= emi;
    stack_full_o <= full;
  endtask : ints
endmodule : core_side_model

// ==== dv/halt_wakeup_reset_control_bench.sv ====
// self-checking bench for the power-down, wake-up and reset controller
`timescale 1ns/1ps
`include "halt_wake_params.svh"

module halt_wakeup_reset_control_bench;
  import halt_wake_pkg::*;
  logic sys_clk_i, rstn_i, sleep_i, clear_watchdog_instruction_i, wdt_ovf_i, emi_i, stack_full_i;
  logic [2:0] int_req_i, int_en_i;
  logic reset_pin_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] port_a_i, wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic osc_run_o, wdt_osc_run_o, wdt_clear_o, hold_o, core_reset_o, opt_load_o;
  logic warm_reset_o, pc_low_clear_o, resume_o, int_ack_o, timeout_flag_o;
  logic power_down_flag_o;
  logic [7:0] interrupt_control_reg_init_o, timer_control_reg_init_o, port_init_o, amp_init_o, conv_ctrl_init_o;
  logic [2:0] conv_clk_init_o;
  logic [31:0] expq[$];
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 67147;

  halt_wakeup_reset_control halt_wakeup_reset_control_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sleep_i(sleep_i), .clear_watchdog_instruction_i(clear_watchdog_instruction_i),
    .wdt_ovf_i(wdt_ovf_i), .int_req_i(int_req_i), .int_en_i(int_en_i), .emi_i(emi_i),
    .stack_full_i(stack_full_i), .reset_pin_n_i(reset_pin_n_i), .port_a_i(port_a_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .osc_run_o(osc_run_o), .wdt_osc_run_o(wdt_osc_run_o), .wdt_clear_o(wdt_clear_o),
    .hold_o(hold_o), .core_reset_o(core_reset_o), .opt_load_o(opt_load_o),
    .warm_reset_o(warm_reset_o), .pc_low_clear_o(pc_low_clear_o), .resume_o(resume_o),
    .int_ack_o(int_ack_o), .timeout_flag_o(timeout_flag_o),
    .power_down_flag_o(power_down_flag_o), .interrupt_control_reg_init_o(interrupt_control_reg_init_o),
    .timer_control_reg_init_o(timer_control_reg_init_o), .port_init_o(port_init_o), .amp_init_o(amp_init_o),
    .conv_ctrl_init_o(conv_ctrl_init_o), .conv_clk_init_o(conv_clk_init_o));

  core_side_model core_side_model_i (
    .sys_clk_i(sys_clk_i), .hold_i(hold_o), .sleep_o(sleep_i), .clear_watchdog_instruction_o(clear_watchdog_instruction_i),
    .wdt_ovf_o(wdt_ovf_i), .int_req_o(int_req_i), .int_en_o(int_en_i), .emi_o(emi_i),
    .stack_full_o(stack_full_i), .reset_pin_n_o(reset_pin_n_i), .port_a_o(port_a_i));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  always #10 sys_clk_i = ~sys_clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat, input logic [31:0] exp);
    if (!we) expq.push_back(exp);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wb

  task automatic wait_run(output int n);
    n = 0;
    while (core_reset_o !== 1'b0) begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask : wait_run

  task automatic wait_wake(output int n);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (resume_o !== 1'b1 && int_ack_o !== 1'b1);
    @(negedge sys_clk_i);
  endtask : wait_wake

  task automatic go_sleep();
    @(posedge sys_clk_i);
    core_side_model_i.instr(1'b1, 1'b0);
    @(negedge sys_clk_i);
  endtask : go_sleep

  // read data and wake results come off the queue in order
  always @(posedge sys_clk_i) begin
    logic [31:0] seen;
    logic got;
    got  = 1'b1;
    seen = {23'h0, 1'b1, 5'h0, int_ack_o, resume_o, warm_reset_o};
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) seen = wb_dat_o;
    else if ((int_ack_o | resume_o | warm_reset_o) !== 1'b1) got = 1'b0;
    if (got && expq.size() == 0) check(seen, ~seen);
    else if (got) check(seen, expq.pop_front());
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int n;
    logic [7:0] wen;
    sys_clk_i = 1'b0;
    rstn_i    = 1'b0;
    wb_cyc_i  = 1'b0;
    wb_stb_i  = 1'b0;
    wb_we_i   = 1'b0;
    wb_adr_i  = 8'h00;
    wb_sel_i  = 4'h0;
    wb_dat_i  = 32'h0;
    wen = (8'($random(seed)) & 8'hFC) | 8'h01;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check({core_reset_o, opt_load_o, wdt_clear_o, hold_o}, 4'hE);
    check({timeout_flag_o, power_down_flag_o}, 2'b00);
    check({interrupt_control_reg_init_o, timer_control_reg_init_o, port_init_o}, 24'h0008FF);
    check({amp_init_o, conv_ctrl_init_o, conv_clk_init_o}, {8'h08, 8'h40, 3'h4});
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    wait_run(n);
    check(32'(n >= 1036 && n <= 1046), 32'h1);
    wb(1'b0, `CTRL_OFS, 4'hF, 32'h0, {30'h0, `CTRL_RST});
    wb(1'b0, `WAKE_EN_OFS, 4'hF, 32'h0, {24'h0, `WAKE_EN_RST});
    wb(1'b1, 8'h0C, 4'hF, $random(seed), 32'h0);
    wb(1'b0, 8'h0C, 4'hF, 32'h0, 32'h0);
    wb(1'b1, `WAKE_EN_OFS, 4'hF, {24'h0, wen}, 32'h0);
    wb(1'b1, `WAKE_EN_OFS, 4'hE, 32'hFF, 32'h0);
    wb(1'b0, `WAKE_EN_OFS, 4'hF, 32'h0, {24'h0, wen});
    wb(1'b1, `STATUS_OFS, 4'hF, 32'hFFFF, 32'h0);
    wb(1'b0, `STATUS_OFS, 4'hF, 32'h0, {22'h0, WK_NONE, S_RUN, 2'b00});
    core_side_model_i.ints(3'b010, 3'b011, 1'b1, 1'b0);
    go_sleep();
    check({osc_run_o, wdt_osc_run_o, hold_o}, 3'b011);
    check(wdt_clear_o, 1'b1);
    check({timeout_flag_o, power_down_flag_o}, 2'b01);
    @(posedge sys_clk_i);
    core_side_model_i.pins(1'b1, 8'hFD);
    repeat (20) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check(hold_o, 1'b1);
    @(posedge sys_clk_i);
    expq.push_back(32'h102);
    core_side_model_i.pins(1'b1, 8'hFE);
    wait_wake(n);
    check(32'(n >= 1024 && n <= 1036), 32'h1);
    check({hold_o, osc_run_o}, 2'b01);
    @(posedge sys_clk_i);
    core_side_model_i.pins(1'b1, 8'hFF);
    core_side_model_i.ints(3'b000, 3'b001, 1'b1, 1'b0);
    core_side_model_i.instr(1'b0, 1'b1);
    @(negedge sys_clk_i);
    check({timeout_flag_o, power_down_flag_o}, 2'b00);
    for (int i = 0; i < 2; i++) begin
      go_sleep();
      @(posedge sys_clk_i);
      expq.push_back(i == 0 ? 32'h104 : 32'h102);
      core_side_model_i.ints(3'b001, 3'b001, 1'b1, 1'(i));
      wait_wake(n);
      check(32'(n >= 1024 && n <= 1036), 32'h1);
      @(posedge sys_clk_i);
      core_side_model_i.ints(3'b000, 3'b001, 1'b1, 1'b0);
    end
    go_sleep();
    @(posedge sys_clk_i);
    expq.push_back(32'h101);
    expq.push_back(32'h102);
    core_side_model_i.ovf();
    @(negedge sys_clk_i);
    check({warm_reset_o, pc_low_clear_o, core_reset_o}, 3'b110);
    check({timeout_flag_o, power_down_flag_o}, 2'b11);
    wait_wake(n);
    check(32'(n >= 1024 && n <= 1036), 32'h1);
    @(posedge sys_clk_i);
    core_side_model_i.ovf();
    @(negedge sys_clk_i);
    check({core_reset_o, timeout_flag_o, power_down_flag_o}, 3'b111);
    wait_run(n);
    check(32'(n >= 1036 && n <= 1046), 32'h1);
    @(posedge sys_clk_i);
    core_side_model_i.instr(1'b0, 1'b1);
    @(negedge sys_clk_i);
    check({timeout_flag_o, power_down_flag_o}, 2'b10);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) go_sleep();
      @(posedge sys_clk_i);
      core_side_model_i.pins(1'b0, 8'hFF);
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check({core_reset_o, opt_load_o, hold_o}, 3'b110);
      check({timeout_flag_o, power_down_flag_o}, i == 0 ? 2'b10 : 2'b01);
      @(posedge sys_clk_i);
      core_side_model_i.pins(1'b1, 8'hFF);
      wait_run(n);
    end
    // watchdog on the instruction clock: nothing of it may run or clear in power-down
    wb(1'b1, `CTRL_OFS, 4'hF, 32'h2, 32'h0);
    wb(1'b0, `CTRL_OFS, 4'hF, 32'h0, 32'h2);
    go_sleep();
    check({wdt_osc_run_o, wdt_clear_o}, 2'b00);
    give_verdict();
  end
endmodule : halt_wakeup_reset_control_bench
